// *** ebus_if.sv ***
`timescale 1ns/1ns
interface ebus_if;
  logic       tcy_en;
  logic       req;
  logic [1:0] waits;
  logic       ale;
  logic       strobe;
  logic       sample;
  logic       done;
  modport ctl (output tcy_en, req, waits, input ale, strobe, sample, done);
  modport seq (input tcy_en, req, waits, output ale, strobe, sample, done);
endinterface : ebus_if

// *** ebus_pkg.sv ***
package ebus_pkg;
  // register byte offsets on the apb side
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] TPTR_OFF = 8'h04;
  localparam logic [7:0] TLAT_OFF = 8'h08;
  localparam logic [7:0] CMD_OFF  = 8'h0c;
  localparam logic [7:0] STAT_OFF = 8'h10;
  localparam logic [7:0] RDAT_OFF = 8'h14;
  // control register layout and reset value
  localparam int         RELEASE_BIT = 7;
  localparam int         WAIT_LSB    = 4;
  localparam int         WMODE_LSB   = 0;
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] CTRL_WMASK  = 8'hb3;
  // command register bits
  localparam int         CMD_RD_BIT = 0;
  localparam int         CMD_WR_BIT = 1;
  // fuse codes and fuse reset values
  localparam logic [1:0] AW_20   = 2'h0;
  localparam logic [1:0] AW_16   = 2'h1;
  localparam logic [1:0] AW_12   = 2'h2;
  localparam logic [1:0] AW_OFF  = 2'h3;
  localparam logic       DW_RST  = 1'h1;
  localparam logic       WEN_RST = 1'h1;
  // instruction cycle is four master clocks
  localparam int         TCY_CLKS = 4;
  localparam logic [1:0] TCY_LAST = 2'(TCY_CLKS - 1);
  // control port bit positions and masks
  localparam int         CTRL_PIN_LSB = 20;
  localparam int         CP_ALE       = 0;
  localparam int         CP_CS        = 5;
  localparam logic [7:0] CP_ALE_M     = 8'h01;
  localparam logic [7:0] CP_RD_M      = 8'h02;
  localparam logic [7:0] CP_WLO_M     = 8'h04;
  localparam logic [7:0] CP_WHI_M     = 8'h08;
  localparam logic [7:0] CP_BAD_M     = 8'h10;
  localparam logic [7:0] CP_CS_M      = 8'h20;
  localparam logic [7:0] CP_LBE_M     = 8'h40;
  localparam logic [7:0] CP_UBE_M     = 8'h80;
  localparam logic [7:0] CP_STRB_M    = 8'hce;
  localparam logic [7:0] CP_IDLE      = 8'hee;
  // bus cycle phases
  typedef enum logic [4:0] {
    SQ_IDLE = 5'h01,
    SQ_ADDR = 5'h02,
    SQ_STRB = 5'h04,
    SQ_WAIT = 5'h08,
    SQ_DONE = 5'h10
  } seq_state_t;
endpackage : ebus_pkg

// *** ebus_seq.sv ***
`timescale 1ns/1ns
module ebus_seq (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // phase link to the access control
  ebus_if.seq      link
);
  ebus_pkg::seq_state_t state_r;
  ebus_pkg::seq_state_t state_nxt;
  logic [1:0]           wcnt_r;
  logic [1:0]           wcnt_nxt;
  logic [1:0]           wq_r;
  logic [4:0]           strb_len_r;

  // one phase per instruction cycle; waits stretch the strobe phase
  always_comb begin
    state_nxt = state_r;
    wcnt_nxt  = wcnt_r;
    if (link.tcy_en) begin
      case (state_r)
        ebus_pkg::SQ_IDLE: begin
          if (link.req) begin
            state_nxt = ebus_pkg::SQ_ADDR;
            wcnt_nxt  = link.waits;
          end
        end
        ebus_pkg::SQ_ADDR: state_nxt = ebus_pkg::SQ_STRB;
        // RL4 added wait cycles
        ebus_pkg::SQ_STRB: begin
          state_nxt = (wcnt_r == 2'h0) ? ebus_pkg::SQ_DONE : ebus_pkg::SQ_WAIT;
        end
        ebus_pkg::SQ_WAIT: begin
          wcnt_nxt  = wcnt_r - 2'h1;
          state_nxt = (wcnt_r == 2'h1) ? ebus_pkg::SQ_DONE : ebus_pkg::SQ_WAIT;
        end
        ebus_pkg::SQ_DONE: state_nxt = ebus_pkg::SQ_IDLE;
        default:           state_nxt = ebus_pkg::SQ_IDLE;
      endcase
    end
  end

  // phase state
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= ebus_pkg::SQ_IDLE;
      wcnt_r  <= 2'h0;
    end else begin
      state_r <= state_nxt;
      wcnt_r  <= wcnt_nxt;
    end
  end

  // phase flags; sample marks the last clock of the strobe phase
  assign link.ale    = (state_r == ebus_pkg::SQ_ADDR);
  assign link.strobe = (state_r == ebus_pkg::SQ_STRB) | (state_r == ebus_pkg::SQ_WAIT);
  assign link.sample = link.tcy_en & link.strobe & (state_nxt == ebus_pkg::SQ_DONE);
  assign link.done   = link.tcy_en & (state_r == ebus_pkg::SQ_DONE);

  // helper: latched wait count and strobe length for the checks
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wq_r       <= 2'h0;
      strb_len_r <= 5'h00;
    end else begin
      if (link.tcy_en & (state_r == ebus_pkg::SQ_IDLE) & link.req) begin
        wq_r <= link.waits;
      end
      strb_len_r <= link.strobe ? strb_len_r + 5'h01 : 5'h00;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_addr_phase;
    link.ale [*4];
  endsequence

  addr_then_strb_a: assert property ($rose(link.ale) |-> s_addr_phase ##1 link.strobe) // RL16
    else $error("address phase not four clocks before strobe");
  strobe_len_a: assert property ($fell(link.strobe) |-> // RL4
      strb_len_r == {({1'b0, wq_r} + 3'h1), 2'h0})
    else $error("strobe length does not match wait count");
  done_once_a: assert property (link.done |=> !link.done [*3])
    else $error("done pulse repeated");
endmodule : ebus_seq

// *** ext_mem_interface.sv ***
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
// What this block does
// RL1: with release bit clear the bus owns its pins and port I/O is off
// RL2: with release bit set pins are ports; bus takes them only while accessing (this block also takes them during external execution)
// RL3: release bit resets to zero, so bus enabled after reset
// RL4: wait field 11/10/01/00 adds 0/1/2/3 instruction cycles per table access
// RL5: word-write mode, odd pointer: table write pulses the high write strobe
// RL6: word-write mode, even pointer: byte goes to holding latch, no strobe
// RL7: byte-select mode: latch byte on both bytes, high strobe plus one byte enable
// RL8: byte-write mode: latch byte on both bytes, high or low strobe by address
// RL9: write mode field ignored with 8-bit data width
// RL10: with external bus disabled the control register ignores writes
// RL11: fixed width setting picks 16-bit data when set, 8-bit when clear
// RL12: fixed setting picks 20, 16 or 12-bit addressing or bus disabled
// RL13: 16-bit addressing frees the four upper address lines as plain I/O
// RL14: freed high pins ignore the release bit and stay general I/O
// RL15: software should pick address width at least the data width
// RL16: 8 or 16-bit data, up to 20-bit address, multiplexed on shared lines
// RL17: pins: ad 0-7, ad 8-15, address 16-19, then control port
// RL18: control port bits: latch, read, write low/high, byte addr, select, byte enables
// RL19: unused control register bits 6 and 3-2 read zero
// RL20: waits apply only when the wait fuse is set, default three
// RL21: idle bus owned: ad lines float, strobes high, latch and byte addr low
// RL22: chip select low on every access, held high during sleep
// RL23: release set while running externally waits until internal execution
module ext_mem_interface (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // fixed settings and core state
  input  wire logic        bus_width_sel_in,
  input  wire logic [1:0]  addr_width_mode_in,
  input  wire logic        wait_fuse_in,
  input  wire logic        exec_ext_in,
  input  wire logic        sleep_in,
  // port I/O from and to the core
  input  wire logic [27:0] gpio_out_in,
  input  wire logic [27:0] gpio_oe_in,
  output logic      [27:0] gpio_in_out,
  // pads
  input  wire logic [27:0] pad_in,
  output logic      [27:0] pad_out_out,
  output logic      [27:0] pad_oe_out
);
  ebus_if link ();

  logic        fuse_ok_r;
  logic        bus_width_sel_r;
  logic [1:0]  addr_width_mode_r;
  logic        wait_en_r;
  logic [7:0]  ext_bus_control_r;
  logic [20:0] table_pointer_r;
  logic [7:0]  table_latch_byte_r;
  logic [7:0]  hold_r;
  logic [7:0]  rdat_r;
  logic        release_eff_r;
  logic        req_r;
  logic        wr_r;
  logic        odd_r;
  logic [19:0] acc_addr_r;
  logic [15:0] acc_data_r;
  logic [7:0]  acc_strb_r;
  logic [1:0]  div_r;
  logic [27:0] pad_s1_r;
  logic [27:0] pad_s2_r;
  logic [27:0] pad_out_r;
  logic [27:0] pad_oe_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic [31:0] rd_val;
  logic        rd_err;

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction : reg_hit

  // settings are fuses: taken once, the cycle after reset release
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fuse_ok_r         <= 1'b0;
      bus_width_sel_r   <= ebus_pkg::DW_RST;
      addr_width_mode_r <= ebus_pkg::AW_OFF;
      wait_en_r         <= ebus_pkg::WEN_RST;
    end else if (!fuse_ok_r) begin
      fuse_ok_r         <= 1'b1;
      // RL11 data width fuse
      bus_width_sel_r   <= bus_width_sel_in;
      // RL12 address width fuse
      addr_width_mode_r <= addr_width_mode_in;
      // RL20 wait enable fuse
      wait_en_r         <= wait_fuse_in;
    end
  end

  // instruction cycle enable divider
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      div_r <= 2'h0;
    end else begin
      div_r <= (div_r == ebus_pkg::TCY_LAST) ? 2'h0 : div_r + 2'h1;
    end
  end
  assign link.tcy_en = (div_r == ebus_pkg::TCY_LAST);

  // apb decode; writes act only in the access cycle
  wire apb_setup = psel_in & ~penable_in;
  wire apb_take  = psel_in & penable_in & pready_r;
  wire apb_wr    = apb_take & pwrite_in;
  wire wr_ctrl   = apb_wr & reg_hit(paddr_in, ebus_pkg::CTRL_OFF);
  wire wr_tptr   = apb_wr & reg_hit(paddr_in, ebus_pkg::TPTR_OFF);
  wire wr_tlat   = apb_wr & reg_hit(paddr_in, ebus_pkg::TLAT_OFF);
  wire wr_cmd    = apb_wr & reg_hit(paddr_in, ebus_pkg::CMD_OFF);

  // bus mode and access decode
  wire       bus_on  = (addr_width_mode_r != ebus_pkg::AW_OFF);
  wire [1:0] wmd     = ext_bus_control_r[ebus_pkg::WMODE_LSB +: 2];
  wire       odd     = table_pointer_r[0];
  // RL9 write modes only with wide data
  wire       word_wr = bus_width_sel_r & wmd[1];
  wire       bsel_wr = bus_width_sel_r & (wmd == 2'h1);
  wire       bwr_wr  = bus_width_sel_r & (wmd == 2'h0);
  wire       idle_ok = bus_on & ~req_r;
  wire       go_rd   = idle_ok & wr_cmd & pwdata_in[ebus_pkg::CMD_RD_BIT];
  wire       want_wr = idle_ok & wr_cmd & ~pwdata_in[ebus_pkg::CMD_RD_BIT]
                       & pwdata_in[ebus_pkg::CMD_WR_BIT];
  // RL6 even word write only loads the holding latch
  wire       hold_ld = want_wr & word_wr & ~odd;
  wire       go_wr   = want_wr & ~hold_ld;

  // RL16 address follows pointer, word address in wide mode
  wire [19:0] bus_addr = bus_width_sel_r ? table_pointer_r[20:1] : table_pointer_r[19:0];
  wire [15:0] bus_data = word_wr ? {table_latch_byte_r, hold_r}
                                 : {table_latch_byte_r, table_latch_byte_r};
  // RL22 select active during access
  wire [7:0]  acc_base = (ebus_pkg::CP_IDLE & ~ebus_pkg::CP_CS_M)
                         | (odd ? ebus_pkg::CP_BAD_M : 8'h00);
  // RL5 word write uses high strobe
  wire [7:0]  low_word = ebus_pkg::CP_WHI_M;
  // RL7 byte select: high strobe plus byte enable
  wire [7:0]  low_bsel = ebus_pkg::CP_WHI_M | (odd ? ebus_pkg::CP_UBE_M : ebus_pkg::CP_LBE_M);
  // RL8 byte write: strobe by addressed byte
  wire [7:0]  low_bwr  = odd ? ebus_pkg::CP_WHI_M : ebus_pkg::CP_WLO_M;
  wire [7:0]  low_wr   = word_wr ? low_word : bsel_wr ? low_bsel
                       : bwr_wr ? low_bwr : ebus_pkg::CP_WLO_M;
  wire [7:0]  low_m    = go_rd ? ebus_pkg::CP_RD_M : low_wr;
  // RL4 wait field inverted gives the added cycles
  wire [1:0]  wait_fld = ext_bus_control_r[ebus_pkg::WAIT_LSB +: 2];
  // RL20 waits gated by the fuse
  assign link.waits = wait_en_r ? ~wait_fld : 2'h0;
  assign link.req   = req_r;

  // access request and latched access parameters
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      req_r      <= 1'b0;
      wr_r       <= 1'b0;
      odd_r      <= 1'b0;
      acc_addr_r <= 20'h00000;
      acc_data_r <= 16'h0000;
      acc_strb_r <= ebus_pkg::CP_IDLE;
    end else if (go_rd | go_wr) begin
      req_r      <= 1'b1;
      wr_r       <= go_wr;
      odd_r      <= odd;
      acc_addr_r <= bus_addr;
      acc_data_r <= bus_data;
      acc_strb_r <= acc_base & ~low_m;
    end else if (link.done) begin
      req_r      <= 1'b0;
    end
  end

  // software registers
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // RL3 release bit and fields reset to zero
      ext_bus_control_r  <= ebus_pkg::CTRL_RST;
      table_pointer_r    <= 21'h000000;
      table_latch_byte_r <= 8'h00;
      hold_r             <= 8'h00;
    end else begin
      // RL10 writes dropped when the bus is disabled
      if (wr_ctrl & bus_on) begin
        // RL19 unused bits kept zero
        ext_bus_control_r <= pwdata_in[7:0] & ebus_pkg::CTRL_WMASK;
      end
      if (wr_tptr & ~req_r) begin
        table_pointer_r <= pwdata_in[20:0];
      end
      if (wr_tlat & ~req_r) begin
        table_latch_byte_r <= pwdata_in[7:0];
      end
      if (hold_ld) begin
        hold_r <= table_latch_byte_r;
      end
    end
  end

  // RL23 release change waits while the core runs from outside
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      release_eff_r <= 1'b0;
    end else if (!exec_ext_in) begin
      release_eff_r <= ext_bus_control_r[ebus_pkg::RELEASE_BIT];
    end
  end

  // RL1 bus holds pins when release is clear
  // RL2 released pins return to the bus only for an access or during external execution
  wire        owned = bus_on & (~release_eff_r | exec_ext_in | req_r);
  // RL13 narrower address drops the high lines
  wire [19:0] lm    = {(addr_width_mode_r == ebus_pkg::AW_20) ? 4'hf : 4'h0,
                       (addr_width_mode_r != ebus_pkg::AW_12) ? 4'hf : 4'h0, 12'hfff};
  // RL11 data lines by width
  wire [15:0] dm    = bus_width_sel_r ? 16'hffff : 16'h00ff;
  // RL21 address lines float outside the address and strobe phases
  wire [19:0] aoe   = link.ale ? lm : link.strobe ? (lm & {4'hf, ~dm}) : 20'h00000;
  wire [19:0] doe   = (link.strobe & wr_r) ? (lm & {4'h0, dm}) : 20'h00000;
  wire [19:0] bus_v = (acc_addr_r & aoe) | ({4'h0, acc_data_r} & doe);
  // RL18 control port pattern per phase
  wire [7:0]  ctl_a = link.ale ? (acc_strb_r | ebus_pkg::CP_STRB_M | ebus_pkg::CP_ALE_M)
                    : link.strobe ? acc_strb_r : ebus_pkg::CP_IDLE;
  // RL22 select forced high in sleep
  wire [7:0]  ctl_v = sleep_in ? (ctl_a | ebus_pkg::CP_CS_M) : ctl_a;
  // RL14 pins outside the bus mask stay with the ports
  wire [27:0] own   = owned ? {8'hff, lm} : 28'h0000000;
  // RL17 pin order: ad low, ad high, upper address, control
  wire [27:0] pad_o = (own & {ctl_v, bus_v}) | (~own & gpio_out_in);
  wire [27:0] pad_e = (own & {8'hff, aoe | doe}) | (~own & gpio_oe_in);

  // pad drive registers and input synchroniser
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pad_out_r <= 28'h0000000;
      pad_oe_r  <= 28'h0000000;
      pad_s1_r  <= 28'h0000000;
      pad_s2_r  <= 28'h0000000;
    end else begin
      pad_out_r <= pad_o;
      pad_oe_r  <= pad_e;
      pad_s1_r  <= pad_in;
      pad_s2_r  <= pad_s1_r;
    end
  end

  // read data taken at the end of the strobe phase
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdat_r <= 8'h00;
    end else if (link.sample & ~wr_r) begin
      rdat_r <= (bus_width_sel_r & odd_r) ? pad_s2_r[15:8] : pad_s2_r[7:0];
    end
  end

  // read mux; unmapped offsets answer with an error
  always_comb begin
    rd_val = 32'h00000000;
    rd_err = 1'b0;
    case (paddr_in)
      ebus_pkg::CTRL_OFF: rd_val = {24'h000000, ext_bus_control_r};
      ebus_pkg::TPTR_OFF: rd_val = {11'h000, table_pointer_r};
      ebus_pkg::TLAT_OFF: rd_val = {24'h000000, table_latch_byte_r};
      ebus_pkg::CMD_OFF:  rd_val = 32'h00000000;
      ebus_pkg::STAT_OFF: rd_val = {25'h0000000, wait_en_r, addr_width_mode_r,
                                    bus_width_sel_r, release_eff_r, owned, req_r};
      ebus_pkg::RDAT_OFF: rd_val = {24'h000000, rdat_r};
      default:            rd_err = 1'b1;
    endcase
  end

  // apb answer: ready in the cycle after setup, one wait-free access
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
    end else if (apb_setup) begin
      pready_r  <= 1'b1;
      pslverr_r <= rd_err;
      prdata_r  <= pwrite_in ? 32'h00000000 : rd_val;
    end else if (apb_take) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata_out  = prdata_r;
  assign pready_out  = pready_r;
  assign pslverr_out = pslverr_r;
  assign pad_out_out = pad_out_r;
  assign pad_oe_out  = pad_oe_r;
  assign gpio_in_out = pad_s2_r;

  ebus_seq u_seq (
    .mclk_in (mclk_in),
    .rstn_in (rstn_in),
    .link    (link)
  );

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_even_word;
    want_wr & word_wr & ~odd;
  endsequence

  unused_zero_a: assert property ((ext_bus_control_r & ~ebus_pkg::CTRL_WMASK) == 8'h00) // RL19
    else $error("unused control bits not zero");
  ctrl_locked_a: assert property (!bus_on |=> ext_bus_control_r == ebus_pkg::CTRL_RST) // RL10
    else $error("control register changed with bus disabled");
  bus_hold_a: assert property ((bus_on & ~release_eff_r) |=> pad_oe_r[27:20] == 8'hff) // RL1
    else $error("control port not driven while bus held");
  free_pins_a: assert property ((addr_width_mode_r == ebus_pkg::AW_16) // RL14
      |=> pad_out_r[19:16] == $past(gpio_out_in[19:16]))
    else $error("freed address pins not following port");
  sleep_cs_a: assert property ((owned & sleep_in) // RL22
      |=> pad_out_r[ebus_pkg::CTRL_PIN_LSB + ebus_pkg::CP_CS])
    else $error("select low during sleep");
  idle_pins_a: assert property ((owned & ~link.ale & ~link.strobe & ~sleep_in) // RL21
      |=> (pad_out_r[27:20] == ebus_pkg::CP_IDLE) && (pad_oe_r[11:0] == 12'h000))
    else $error("idle bus pins wrong");
  defer_rel_a: assert property (exec_ext_in |=> $stable(release_eff_r)) // RL23
    else $error("release changed during external execution");
  even_hold_a: assert property (s_even_word |=> !req_r && hold_r == $past(table_latch_byte_r)) // RL6
    else $error("even word write started a bus cycle");
  ale_pin_a: assert property ((owned & link.ale) // RL18
      |=> pad_out_r[ebus_pkg::CTRL_PIN_LSB + ebus_pkg::CP_ALE] ##4 !pad_out_r[20])
    else $error("latch strobe timing wrong");
  apb_answer_a: assert property (apb_setup |=> pready_out ##1 !pready_out)
    else $error("apb answer not one cycle after setup");
endmodule : ext_mem_interface

// *** external_memory_bus_interface_tb.sv ***
`timescale 1ns/1ns
module external_memory_bus_interface_tb;
  logic        clk = 1'b0, rstn = 1'b0, sel = 1'b0, en = 1'b0, wr = 1'b0;
  logic [7:0]  adr = 8'h00, lat;
  logic [31:0] wd = 32'h0, rdo, q;
  logic        rdy, err, e, mdr, dw = 1'b1, wf = 1'b1, ext = 1'b0, slp = 1'b0;
  logic [1:0]  am = 2'h0;
  logic [27:0] go = 28'h5a5a5a5, ge = 28'hfffffff, noise = 28'h0;
  logic [27:0] gi, pad, po, poe, mdrv;
  logic [15:0] mrd, maddr, mwd;
  logic [1:0]  wmd [6] = '{2'h2, 2'h2, 2'h0, 2'h0, 2'h1, 2'h1};
  logic [3:0]  ef [6] = '{4'h0, 4'h2, 4'h1, 4'h2, 4'h6, 4'ha};
  int          fail_count = 0, checked = 0, cnt [8];
  always #25 clk = ~clk;
  // released lines show a pattern that changes every cycle, not a held value
  always @(posedge clk) noise <= ~noise;
  assign mdrv = mdr ? 28'h000ffff : 28'h0000000;
  assign pad = (poe & po) | (~poe & ((mdrv & {12'h000, mrd}) | (~mdrv & noise)));
  // low-time of each driven control pin except the latch strobe
  always @(posedge clk) begin
    for (int i = 1; i < 8; i++) if (poe[20+i] && !po[20+i]) cnt[i]++;
  end
  ext_mem_interface DUT (
    .mclk_in(clk), .rstn_in(rstn), .psel_in(sel), .penable_in(en), .pwrite_in(wr),
    .paddr_in(adr), .pwdata_in(wd), .prdata_out(rdo), .pready_out(rdy),
    .pslverr_out(err), .bus_width_sel_in(dw), .addr_width_mode_in(am),
    .wait_fuse_in(wf), .exec_ext_in(ext), .sleep_in(slp), .gpio_out_in(go),
    .gpio_oe_in(ge), .gpio_in_out(gi), .pad_in(pad), .pad_out_out(po), .pad_oe_out(poe));
  mem_model mem (.mclk_in(clk), .pad_in(pad), .rdat_out(mrd), .rdrv_out(mdr),
    .addr_out(maddr), .wdat_out(mwd));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    sel <= 1'b1;
    en <= 1'b0;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    q = rdo;
    e = err;
    sel <= 1'b0;
    en <= 1'b0;
    @(posedge clk);
  endtask : apb
  // start a table access and poll busy
  task automatic cmd(input logic [31:0] c);
    cnt = '{default: 0};
    apb(1'b1, ebus_pkg::CMD_OFF, c);
    do begin
      apb(1'b0, ebus_pkg::STAT_OFF, 32'h0);
    end while (q[0] !== 1'b0);
  endtask : cmd
  task automatic rst(input logic b, input logic [1:0] m, input logic f);
    rstn <= 1'b0;
    dw <= b;
    am <= m;
    wf <= f;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : rst
  initial begin
    #1000000;
    fail_count++;
    give_verdict();
  end
  initial begin
    rst(1'b1, ebus_pkg::AW_20, 1'b1);
    apb(1'b0, ebus_pkg::CTRL_OFF, 32'h0);
    chk("ctrl reset", 32'h0, q);
    chk("idle ctl", 8'hee, po[27:20]);
    chk("ad float", 28'hff00000, poe);
    apb(1'b1, ebus_pkg::CTRL_OFF, 32'hffffffff);
    apb(1'b0, ebus_pkg::CTRL_OFF, 32'h0);
    chk("ctrl bits", 32'hb3, q);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 1'b1, e);
    $display("test registers done");
    for (int w = 0; w < 4; w++) begin
      apb(1'b1, ebus_pkg::CTRL_OFF, 32'(w << 4));
      apb(1'b1, ebus_pkg::TPTR_OFF, 32'h12345);
      cmd(32'h1);
      chk("read low", 32'(4 * (4 - w)), cnt[1]);
      chk("addr", 16'h91a2, maddr);
      apb(1'b0, ebus_pkg::RDAT_OFF, 32'h0);
      chk("read byte", 32'h5d, q);
    end
    $display("test waits done");
    for (int i = 0; i < 6; i++) begin
      lat = 8'(8'h11 * (i + 1));
      apb(1'b1, ebus_pkg::CTRL_OFF, {30'h0000000c, wmd[i]});
      apb(1'b1, ebus_pkg::TPTR_OFF, 32'(32'h100 + i));
      apb(1'b1, ebus_pkg::TLAT_OFF, {24'h0, lat});
      cmd(32'h2);
      chk("strobes", ef[i], {cnt[7] > 0, cnt[6] > 0, cnt[3] > 0, cnt[2] > 0});
      if (ef[i] != 4'h0) chk("wdata", (i == 1) ? 16'h2211 : {lat, lat}, mwd);
    end
    $display("test writes done");
    apb(1'b1, ebus_pkg::CTRL_OFF, 32'h80);
    repeat (4) @(posedge clk);
    chk("rel oe", ge, poe);
    chk("rel out", go, po);
    chk("sync in", go, gi);
    cmd(32'h1);
    chk("rel read", 32'd16, cnt[1]);
    ext <= 1'b1;
    repeat (4) @(posedge clk);
    chk("ext owned", 8'hee, po[27:20]);
    ext <= 1'b0;
    slp <= 1'b1;
    apb(1'b1, ebus_pkg::CTRL_OFF, 32'h30);
    // pins still show the port select level until the release bit settles
    repeat (2) @(posedge clk);
    cmd(32'h1);
    chk("cs sleep", 32'h0, cnt[5]);
    slp <= 1'b0;
    cmd(32'h1);
    chk("cs low", 32'h8, cnt[5]);
    $display("test ownership done");
    rst(1'b0, ebus_pkg::AW_16, 1'b0);
    apb(1'b1, ebus_pkg::CTRL_OFF, 32'h2);
    apb(1'b1, ebus_pkg::TPTR_OFF, 32'habc);
    cmd(32'h1);
    chk("no waits", 32'h4, cnt[1]);
    chk("addr 8b", 16'h0abc, maddr);
    apb(1'b0, ebus_pkg::RDAT_OFF, 32'h0);
    chk("byte 8b", 32'hbc, q);
    apb(1'b1, ebus_pkg::TLAT_OFF, 32'h77);
    cmd(32'h2);
    chk("8b write", 4'h1, {cnt[7] > 0, cnt[6] > 0, cnt[3] > 0, cnt[2] > 0});
    chk("upper out", go[19:16], po[19:16]);
    chk("upper oe", ge[19:16], poe[19:16]);
    $display("test narrow done");
    rst(1'b1, ebus_pkg::AW_OFF, 1'b1);
    apb(1'b1, ebus_pkg::CTRL_OFF, 32'h80);
    apb(1'b0, ebus_pkg::CTRL_OFF, 32'h0);
    chk("ctrl locked", 32'h0, q);
    chk("bus off", go, po);
    $display("test bus off done");
    give_verdict();
  end
endmodule : external_memory_bus_interface_tb

// *** mem_model.sv ***
`timescale 1ns/1ns
module mem_model (
  // clock
  input  wire logic        mclk_in,
  // resolved pad levels
  input  wire logic [27:0] pad_in,
  // read data onto the ad lines
  output logic      [15:0] rdat_out,
  output logic             rdrv_out,
  // last address and write data seen
  output logic      [15:0] addr_out,
  output logic      [15:0] wdat_out
);
  // address taken while latch strobe high, data while a write strobe low
  always @(posedge mclk_in) begin
    if (pad_in[20]) begin
      addr_out <= pad_in[15:0];
    end
    if (!pad_in[25] && !(pad_in[22] && pad_in[23])) begin
      wdat_out <= pad_in[15:0];
    end
  end
  // answers at once; only while selected and read strobe low
  assign rdrv_out = !pad_in[25] && !pad_in[21];
  assign rdat_out = {~addr_out[7:0], addr_out[7:0]};
endmodule : mem_model
